// >>> hw/lgc_logic_cell.sv
// Purpose: One configurable logic cell with an AXI4-Lite config port.
// Assumes: All cell inputs are synchronous to aclk.
// Notes:   Cell clock edges are detected by sampling against aclk.
//
// Overview of operation
// - Two 16-entry one-bit tables each give any function of four inputs.
// - A third table gives any function of its three inputs.
// - Two third-table inputs are muxed from a quad table or a cell input.
// - The three tables together cover any five-input function.
// - Two combinational outputs leave the cell, each registered on aclk.
// - Two storage elements take a table output or the direct input.
// - The aux input reaches either element through the third table.
// - Both elements share clock, clock enable and set/reset.
// - Global init forces both elements to their configured value.
// - Set/reset forces the value, else an enabled edge captures data.
// - In latch mode an element passes data while clock low and enabled.
// - Every storage element has a clock enable.
// - Each element picks the rising or falling edge of the clock.
// - Unused enable is active, unused set/reset inactive, active high.
// - Each element's set-or-reset choice also sets its init state.
// - Outputs pick first table or third table, second table or third.
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`default_nettype none
`include "lgc_defs.svh"

module lgc_logic_cell
  import lgc_pkg::*;
#(
  parameter bit LATCH_SUPPORT = 1'b1
) (
  input  wire logic        aclk,                // System clock.
  input  wire logic        aresetn,             // Sync reset, active low.
  input  wire logic [7:0]  s_axi_awaddr,        // Write address.
  input  wire logic        s_axi_awvalid,       // Write address valid.
  output logic             s_axi_awready,       // Write address ready.
  input  wire logic [31:0] s_axi_wdata,         // Write data.
  input  wire logic [3:0]  s_axi_wstrb,         // Write byte strobes.
  input  wire logic        s_axi_wvalid,        // Write data valid.
  output logic             s_axi_wready,        // Write data ready.
  output logic [1:0]       s_axi_bresp,         // Write response.
  output logic             s_axi_bvalid,        // Write response valid.
  input  wire logic        s_axi_bready,        // Write response ready.
  input  wire logic [7:0]  s_axi_araddr,        // Read address.
  input  wire logic        s_axi_arvalid,       // Read address valid.
  output logic             s_axi_arready,       // Read address ready.
  output logic [31:0]      s_axi_rdata,         // Read data.
  output logic [1:0]       s_axi_rresp,         // Read response.
  output logic             s_axi_rvalid,        // Read data valid.
  input  wire logic        s_axi_rready,        // Read data ready.
  input  wire logic [3:0]  first_table_inputs,  // First quad table inputs.
  input  wire logic [3:0]  second_table_inputs, // Second quad table inputs.
  input  wire logic        aux_table_input,     // Third table input 1.
  input  wire logic        direct_in,           // Direct data input.
  input  wire logic        cell_clock,          // Shared storage clock.
  input  wire logic        cell_clock_enable,   // Shared enable, high.
  input  wire logic        cell_set_reset,      // Shared set/reset, high.
  input  wire logic        global_init,         // Global init, high.
  output logic             x_out,               // First comb output.
  output logic             y_out,               // Second comb output.
  output logic [1:0]       q_out                // Storage outputs.
);

  // ============================================================
  // Configuration registers and bus state.
  logic [15:0] cfg_f, next_cfg_f;
  logic [15:0] cfg_g, next_cfg_g;
  logic [7:0]  cfg_h, next_cfg_h;
  logic [14:0] cfg_c, next_cfg_c;
  logic        aw_full, next_aw_full;
  logic        w_full, next_w_full;
  logic [7:0]  aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        bvalid, next_bvalid;
  logic [1:0]  bresp, next_bresp;
  logic        rvalid, next_rvalid;
  logic [1:0]  rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  lgc_reg_t    wr_sel;
  lgc_reg_t    rd_sel;
  logic        do_write;

  // Map a byte address onto a register.
  function automatic lgc_reg_t reg_decode(input logic [7:0] addr);
    case (addr)
      `LGC_OFS_FTAB: reg_decode = LGC_REG_F;
      `LGC_OFS_GTAB: reg_decode = LGC_REG_G;
      `LGC_OFS_HTAB: reg_decode = LGC_REG_H;
      `LGC_OFS_CTRL: reg_decode = LGC_REG_CTRL;
      `LGC_OFS_STAT: reg_decode = LGC_REG_STAT;
      default:       reg_decode = LGC_REG_NONE;
    endcase
  endfunction : reg_decode

  // Merge a write into a stored word under byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    merge = res;
  endfunction : merge

  // ============================================================
  // Table paths and steering.
  logic       f_val, g_val, h_val;
  logic       h_in0, h_in2;
  logic [1:0] d_in;
  logic [1:0] clk_eff, clk_eff_prev;
  logic       clk_prev, next_clk_prev;
  logic       en_eff, sr_eff;
  logic [1:0] q, next_q;
  logic       x_r, next_x_r, y_r, next_y_r;

  // Quad tables and the third table with its input muxes.
  always_comb begin
    f_val = cfg_f[first_table_inputs];
    g_val = cfg_g[second_table_inputs];
    h_in0 = cfg_c[`LGC_C_H0SEL] ? g_val : cell_set_reset;
    h_in2 = cfg_c[`LGC_C_H2SEL] ? f_val : direct_in;
    h_val = cfg_h[{h_in2, aux_table_input, h_in0}];
  end

  // Data source select for each element, table or direct input.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      unique case (lgc_src_t'(cfg_c[`LGC_C_DSEL0 + 2*i +: 2]))
        LGC_SRC_F:   d_in[i] = f_val;
        LGC_SRC_G:   d_in[i] = g_val;
        LGC_SRC_H:   d_in[i] = h_val;
        LGC_SRC_DIN: d_in[i] = direct_in;
      endcase
    end
  end

  // Shared controls with defaults for unused enable and set/reset.
  always_comb begin
    en_eff  = !cfg_c[`LGC_C_CEUSE] || cell_clock_enable;
    sr_eff  = cfg_c[`LGC_C_SRUSE] && cell_set_reset;
    clk_eff = {cell_clock, cell_clock} ^ cfg_c[`LGC_C_INV0 +: 2];
    clk_eff_prev = {clk_prev, clk_prev} ^ cfg_c[`LGC_C_INV0 +: 2];
  end

  // Storage elements and the two registered combinational outputs.
  always_comb begin
    next_clk_prev = cell_clock;
    next_x_r = cfg_c[`LGC_C_XSEL] ? h_val : f_val;
    next_y_r = cfg_c[`LGC_C_YSEL] ? h_val : g_val;
    next_q   = q;
    for (int i = 0; i < 2; i++) begin
      if (global_init || sr_eff) begin
        next_q[i] = cfg_c[`LGC_C_SETV0 + i];
      end else if (LATCH_SUPPORT && cfg_c[`LGC_C_LATCH]) begin
        if (!clk_eff[i] && en_eff) begin
          next_q[i] = d_in[i];
        end
      end else if (clk_eff[i] && !clk_eff_prev[i] && en_eff) begin
        next_q[i] = d_in[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q        <= 2'h0;
      clk_prev <= 1'b0;
      x_r      <= 1'b0;
      y_r      <= 1'b0;
    end else begin
      q        <= next_q;
      clk_prev <= next_clk_prev;
      x_r      <= next_x_r;
      y_r      <= next_y_r;
    end
  end

  // ============================================================
  // AXI4-Lite slave.
  always_comb begin
    wr_sel   = reg_decode(aw_addr);
    rd_sel   = reg_decode(s_axi_araddr);
    do_write = aw_full && w_full && !bvalid;
    next_aw_full = aw_full;
    next_w_full  = w_full;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_cfg_f   = cfg_f;
    next_cfg_g   = cfg_g;
    next_cfg_h   = cfg_h;
    next_cfg_c   = cfg_c;
    if (s_axi_awvalid && !aw_full) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_full) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = `LGC_RESP_OKAY;
      unique case (wr_sel)
        LGC_REG_F:
          next_cfg_f = 16'(merge({16'h0000, cfg_f}, w_data, w_strb));
        LGC_REG_G:
          next_cfg_g = 16'(merge({16'h0000, cfg_g}, w_data, w_strb));
        LGC_REG_H:
          next_cfg_h = 8'(merge({24'h000000, cfg_h}, w_data, w_strb));
        LGC_REG_CTRL:
          next_cfg_c = 15'(merge({17'h00000, cfg_c}, w_data, w_strb));
        LGC_REG_STAT: next_bresp = `LGC_RESP_OKAY;
        default:      next_bresp = `LGC_RESP_SLV;
      endcase
    end
  end

  // Read channel: one read outstanding, answer one cycle after address.
  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp  = `LGC_RESP_OKAY;
      unique case (rd_sel)
        LGC_REG_F:    next_rdata = {16'h0000, cfg_f};
        LGC_REG_G:    next_rdata = {16'h0000, cfg_g};
        LGC_REG_H:    next_rdata = {24'h000000, cfg_h};
        LGC_REG_CTRL: next_rdata = {17'h00000, cfg_c};
        LGC_REG_STAT: next_rdata = {28'h0000000, y_r, x_r, q};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = `LGC_RESP_SLV;
        end
      endcase
    end
  end

  // Configuration is static apart from bus writes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_f   <= `LGC_RST_QTAB;
      cfg_g   <= `LGC_RST_QTAB;
      cfg_h   <= `LGC_RST_HTAB;
      cfg_c   <= `LGC_RST_CTRL;
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= `LGC_RESP_OKAY;
      rvalid  <= 1'b0;
      rresp   <= `LGC_RESP_OKAY;
      rdata   <= 32'h00000000;
    end else begin
      cfg_f   <= next_cfg_f;
      cfg_g   <= next_cfg_g;
      cfg_h   <= next_cfg_h;
      cfg_c   <= next_cfg_c;
      aw_full <= next_aw_full;
      w_full  <= next_w_full;
      aw_addr <= next_aw_addr;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rresp   <= next_rresp;
      rdata   <= next_rdata;
    end
  end

  // Output drive.
  assign s_axi_awready = !aw_full;
  assign s_axi_wready  = !w_full;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rresp   = rresp;
  assign s_axi_rdata   = rdata;
  assign x_out         = x_r;
  assign y_out         = y_r;
  assign q_out         = q;

  // ============================================================
  // Assertions.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_ftab;
    !cfg_c[`LGC_C_XSEL] ##1 $stable(cfg_f) |->
      x_out == $past(cfg_f[first_table_inputs]);
  endproperty
  a_ftab: assert property (p_ftab) else $error("x_out not F table");

  property p_gtab;
    !cfg_c[`LGC_C_YSEL] ##1 $stable(cfg_g) |->
      y_out == $past(cfg_g[second_table_inputs]);
  endproperty
  a_gtab: assert property (p_gtab) else $error("y_out not G table");

  property p_htab;
    cfg_c[`LGC_C_XSEL] && !cfg_c[`LGC_C_H0SEL] && !cfg_c[`LGC_C_H2SEL]
      ##1 $stable(cfg_h) |->
      x_out == $past(cfg_h[{direct_in, aux_table_input, cell_set_reset}]);
  endproperty
  a_htab: assert property (p_htab) else $error("x_out not H table");

  property p_init;
    global_init |=> q_out == $past(cfg_c[`LGC_C_SETV0 +: 2]);
  endproperty
  a_init: assert property (p_init) else $error("init value wrong");

  property p_sr;
    cell_set_reset && cfg_c[`LGC_C_SRUSE] |=>
      q_out == $past(cfg_c[`LGC_C_SETV0 +: 2]);
  endproperty
  a_sr: assert property (p_sr) else $error("set/reset ignored");

  property p_hold;
    cfg_c[`LGC_C_CEUSE] && !cell_clock_enable && !global_init &&
      !(cell_set_reset && cfg_c[`LGC_C_SRUSE]) |=> $stable(q_out);
  endproperty
  a_hold: assert property (p_hold) else $error("q moved, enable low");

  property p_capture;
    !global_init && !sr_eff && en_eff && !cfg_c[`LGC_C_LATCH] &&
      !cfg_c[`LGC_C_INV0] && cell_clock && !clk_prev |=>
      q_out[0] == $past(d_in[0]);
  endproperty
  a_capture: assert property (p_capture) else $error("no capture");

  property p_noedge;
    !global_init && !sr_eff && !cfg_c[`LGC_C_LATCH] &&
      cell_clock == clk_prev |=> $stable(q_out);
  endproperty
  a_noedge: assert property (p_noedge) else $error("q moved, no edge");

  property p_fall;
    !global_init && !sr_eff && en_eff && !cfg_c[`LGC_C_LATCH] &&
      cfg_c[`LGC_C_INV0 + 1] && !cell_clock && clk_prev |=>
      q_out[1] == $past(d_in[1]);
  endproperty
  a_fall: assert property (p_fall) else $error("falling edge missed");

  property p_latch;
    !global_init && !sr_eff && en_eff && cfg_c[`LGC_C_LATCH] &&
      !clk_eff[0] |=> q_out[0] == $past(d_in[0]);
  endproperty
  a_latch: assert property (p_latch) else $error("latch not open");

  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read:  cover property (s_axi_rvalid && s_axi_rready);
  c_latch: cover property (cfg_c[`LGC_C_LATCH] && q_out[0] != $past(q_out[0]));
  c_h_out: cover property (cfg_c[`LGC_C_XSEL] && x_out);

endmodule : lgc_logic_cell
`default_nettype wire

// >>> hw/lgc_defs.svh
// Purpose: Register offsets, field positions and reset values of the cell.
// Assumes: Included by the cell package and design files by bare name.
// Notes:   Definitions only.
`ifndef LGC_DEFS_SVH
`define LGC_DEFS_SVH

// ============================================================
// Register byte offsets.
`define LGC_OFS_FTAB   8'h00
`define LGC_OFS_GTAB   8'h04
`define LGC_OFS_HTAB   8'h08
`define LGC_OFS_CTRL   8'h0C
`define LGC_OFS_STAT   8'h10

// ============================================================
// Reset values of the configuration registers.
`define LGC_RST_QTAB   16'h0000
`define LGC_RST_HTAB   8'h00
`define LGC_RST_CTRL   15'h0000

// ============================================================
// Control register field positions.
`define LGC_C_H0SEL    0
`define LGC_C_H2SEL    1
`define LGC_C_XSEL     2
`define LGC_C_YSEL     3
`define LGC_C_DSEL0    4
`define LGC_C_DSEL1    6
`define LGC_C_INV0     8
`define LGC_C_SETV0    10
`define LGC_C_LATCH    12
`define LGC_C_CEUSE    13
`define LGC_C_SRUSE    14

// ============================================================
// Bus response codes.
`define LGC_RESP_OKAY  2'h0
`define LGC_RESP_SLV   2'h2

`endif

// >>> hw/lgc_pkg.sv
// Purpose: Types shared by the logic cell design.
// Assumes: lgc_defs.svh is on the include path.
// Notes:   Constants live in the defines header.
`default_nettype none
`include "lgc_defs.svh"

package lgc_pkg;

  // ============================================================
  // Storage element data source selection.
  typedef enum logic [1:0] {
    LGC_SRC_F   = 2'h0,
    LGC_SRC_G   = 2'h1,
    LGC_SRC_H   = 2'h2,
    LGC_SRC_DIN = 2'h3
  } lgc_src_t;

  // Register decode result.
  typedef enum logic [2:0] {
    LGC_REG_F    = 3'h0,
    LGC_REG_G    = 3'h1,
    LGC_REG_H    = 3'h2,
    LGC_REG_CTRL = 3'h3,
    LGC_REG_STAT = 3'h4,
    LGC_REG_NONE = 3'h7
  } lgc_reg_t;

endpackage : lgc_pkg
`default_nettype wire

// >>> tb/lgc_fabric_model.sv
// Purpose: Routing fabric model that drives the cell's logic inputs.
// Assumes: The bench calls drive once per step, from its main sequence.
// Notes:   Values change only just after a rising aclk edge.
`default_nettype none

module lgc_fabric_model (
  input  wire logic  aclk,                // System clock.
  output logic [3:0] first_table_inputs,  // First quad table inputs.
  output logic [3:0] second_table_inputs, // Second quad table inputs.
  output logic       aux_table_input,     // Third table input 1.
  output logic       direct_in,           // Direct data input.
  output logic       cell_clock,          // Shared storage clock.
  output logic       cell_clock_enable,   // Shared enable.
  output logic       cell_set_reset,      // Shared set/reset.
  output logic       global_init          // Global init.
);
  timeunit 1ns;
  timeprecision 1ps;

  // ============================================================
  // Start quiet so that nothing looks like a clock edge at reset.
  initial begin
    {global_init, cell_set_reset, cell_clock_enable, cell_clock,
     direct_in, aux_table_input, second_table_inputs,
     first_table_inputs} = 14'h0000;
  end

  // Launch one set of routed values just after the next edge.
  task automatic drive(input logic [13:0] v);
    @(posedge aclk);
    {global_init, cell_set_reset, cell_clock_enable, cell_clock,
     direct_in, aux_table_input, second_table_inputs,
     first_table_inputs} <= v;
  endtask : drive
endmodule : lgc_fabric_model
`default_nettype wire

// >>> tb/lgc_logic_cell_tb_top.sv
// Purpose: Self-checking bench for the configurable logic cell.
// Assumes: Expectations are queued by the driver, compared by a monitor.
// Notes:   Each cell step waits one aclk for the registered outputs.
`default_nettype none
`include "lgc_defs.svh"

module lgc_logic_cell_tb_top
  import lgc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ============================================================
  // Bench signals and scoreboard queues.
  localparam logic [1:0] OK  = `LGC_RESP_OKAY;
  localparam logic [1:0] SLV = `LGC_RESP_SLV;
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0000_0000;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        probe   = 1'b0;
  wire logic   awready, wready, bvalid, arready, rvalid, x_out, y_out;
  wire logic [1:0]  bresp, rresp, q_out;
  wire logic [31:0] rdata;
  wire logic [3:0]  fti, sti;
  wire logic        aux, din, ck_w, ce_w, sr_w, gi_w;
  int          error_cnt = 0;
  int          checks    = 0;
  logic [33:0] rd_q[$];
  logic [1:0]  wr_q[$];
  logic [7:0]  cell_q[$];
  logic [15:0] seed = 16'h582B;
  logic [15:0] ftab, gtab;
  logic [7:0]  htab;
  logic [31:0] ctl;
  logic [3:0]  fi = 4'h0;
  logic [3:0]  gi4 = 4'h0;
  logic        ax = 1'b0, dn = 1'b0, ck = 1'b0, ce = 1'b0;
  logic        sr = 1'b0, gin = 1'b0, f, g, h;

  // Free-running 100 MHz system clock.
  initial begin
    forever #5 aclk = ~aclk;
  end

  lgc_logic_cell dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .first_table_inputs(fti), .second_table_inputs(sti),
    .aux_table_input(aux), .direct_in(din), .cell_clock(ck_w),
    .cell_clock_enable(ce_w), .cell_set_reset(sr_w),
    .global_init(gi_w), .x_out(x_out), .y_out(y_out), .q_out(q_out));

  lgc_fabric_model fab (
    .aclk(aclk), .first_table_inputs(fti), .second_table_inputs(sti),
    .aux_table_input(aux), .direct_in(din), .cell_clock(ck_w),
    .cell_clock_enable(ce_w), .cell_set_reset(sr_w), .global_init(gi_w));

  // ============================================================
  // Helpers.
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic check(input string nm, input logic [33:0] e,
                       input logic [33:0] s);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  task automatic conclude();
    error_cnt += rd_q.size() + wr_q.size() + cell_q.size();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  // One write: address and data offered together, each freed when taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    int n;
    n = 0;
    wr_q.push_back(r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
  endtask : axi_wr

  // One read; the monitor compares the data at the accepting edge.
  task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    n = 0;
    rd_q.push_back(e);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
  endtask : axi_rd

  // Route one input set, then probe {y, x, q1, q0} under a mask.
  task automatic apply(input logic [3:0] m, input logic [3:0] e);
    fab.drive({gin, sr, ce, ck, dn, ax, gi4, fi});
    @(posedge aclk);
    cell_q.push_back({m, e & m});
    probe <= 1'b1;
    @(posedge aclk);
    probe <= 1'b0;
  endtask : apply

  // Monitor: every result that appears takes the oldest expectation.
  always @(posedge aclk) begin
    if (rvalid && rready) check("read", rd_q.pop_front(), {rresp, rdata});
    if (bvalid && bready) check("bresp", 34'(wr_q.pop_front()), 34'(bresp));
    if (probe) check("cell", 34'(cell_q[0][3:0]),
                     34'({y_out, x_out, q_out} & cell_q[0][7:4]));
    if (probe) void'(cell_q.pop_front());
  end

  // Watchdog that cuts a hung run short.
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    conclude();
  end

  // ============================================================
  // Main sequence.
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a <= 20; a += 4)
      axi_rd(8'(a), {a == 20 ? SLV : OK, 32'h0});
    axi_wr(8'h14, 32'h0, SLV);
    axi_wr(`LGC_OFS_STAT, 32'hF, OK);
    axi_rd(`LGC_OFS_STAT, {OK, 32'h0});
    // Random tables and output routing against a reference model.
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      ftab = seed;
      seed = lfsr(seed);
      gtab = seed;
      seed = lfsr(seed);
      htab = seed[7:0];
      ctl = {28'h0, seed[11:8]};
      axi_wr(`LGC_OFS_FTAB, {16'h0, ftab}, OK);
      axi_wr(`LGC_OFS_GTAB, {16'h0, gtab}, OK);
      axi_wr(`LGC_OFS_HTAB, {24'h0, htab}, OK);
      axi_wr(`LGC_OFS_CTRL, ctl, OK);
      axi_rd(`LGC_OFS_GTAB, {OK, 16'h0, gtab});
      for (int j = 0; j < 4; j++) begin
        seed = lfsr(seed);
        {sr, ax, dn, gi4, fi} = seed[10:0];
        f = ftab[fi];
        g = gtab[gi4];
        h = htab[{ctl[1] ? f : dn, ax, ctl[0] ? g : sr}];
        apply(4'hC, {ctl[3] ? h : g, ctl[2] ? h : f, 2'b00});
      end
    end
    // Flip-flops: element 1 on the falling edge, set/reset and init.
    ctl = (32'(LGC_SRC_DIN) << `LGC_C_DSEL0)
        | (32'(LGC_SRC_F) << `LGC_C_DSEL1) | (32'h1 << (`LGC_C_INV0 + 1))
        | (32'h1 << `LGC_C_SETV0) | (32'h1 << `LGC_C_CEUSE)
        | (32'h1 << `LGC_C_SRUSE);
    // Drop any random set/reset before it is enabled by the control word.
    sr = 1'b0;
    fab.drive({gin, sr, ce, ck, dn, ax, gi4, fi});
    axi_wr(`LGC_OFS_FTAB, 32'h0002, OK);
    axi_wr(`LGC_OFS_CTRL, ctl, OK);
    axi_rd(`LGC_OFS_CTRL, {OK, ctl});
    {ck, ce, sr, dn, fi} = 8'b0101_0000;
    apply(4'h3, 4'h0);
    {ck, fi} = {1'b1, 4'h1};
    apply(4'h3, 4'h1);
    ck = 1'b0;
    apply(4'h3, 4'h3);
    {ce, dn, ck} = 3'b001;
    apply(4'h3, 4'h3);
    ck = 1'b0;
    apply(4'h3, 4'h3);
    {ce, ck} = 2'b11;
    apply(4'h3, 4'h2);
    {sr, ck} = 2'b10;
    apply(4'h3, 4'h1);
    {sr, ck} = 2'b01;
    apply(4'h3, 4'h0);
    {gin, ck} = 2'b10;
    apply(4'h3, 4'h1);
    gin = 1'b0;
    // Latch mode on element 0.
    ctl = (32'h1 << `LGC_C_LATCH) | (32'(LGC_SRC_DIN) << `LGC_C_DSEL0)
        | (32'h1 << `LGC_C_CEUSE);
    axi_wr(`LGC_OFS_CTRL, ctl, OK);
    {ck, ce, dn} = 3'b011;
    apply(4'h1, 4'h1);
    dn = 1'b0;
    apply(4'h1, 4'h0);
    {ck, dn} = 2'b11;
    apply(4'h1, 4'h0);
    {ck, ce} = 2'b00;
    apply(4'h1, 4'h0);
    ce = 1'b1;
    apply(4'h1, 4'h1);
    // Unused enable and set/reset; aux input reaches element 0.
    ctl = (32'(LGC_SRC_H) << `LGC_C_DSEL0) | (32'h1 << `LGC_C_SETV0);
    axi_wr(`LGC_OFS_HTAB, 32'hCC, OK);
    axi_wr(`LGC_OFS_CTRL, ctl, OK);
    {ck, ce, sr, ax} = 4'b0010;
    apply(4'h1, 4'h1);
    ck = 1'b1;
    apply(4'h1, 4'h0);
    {ck, ax} = 2'b01;
    apply(4'h1, 4'h0);
    ck = 1'b1;
    apply(4'h1, 4'h1);
    repeat (2) @(posedge aclk);
    conclude();
  end
endmodule : lgc_logic_cell_tb_top
`default_nettype wire
